// ==== hw/hbridge_motor_control.sv ====
// h-bridge motor control: direction decode, regulation, protection
// assumes raw pins and comparator levels from outside; wishbone classic bus
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps

module hbridge_motor_control #(
  parameter int ADC_W = hbridge_pkg::ADC_W_DEF,
  parameter int ILIM_FAULT_CYC = hbridge_pkg::ILIM_FAULT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // host pins
  input wire logic dir_ctrl_a_i,
  input wire logic dir_ctrl_b_i,
  output logic error_flag_n_o,
  // analog front end
  input wire logic [ADC_W-1:0] speed_setpoint_in_i,
  input wire logic [ADC_W-1:0] bridge_avg_i,
  input wire logic [ADC_W+1:0] supply_level_i,
  input wire logic current_sense_in_i,
  input wire logic [3:0] fet_overcurrent_i,
  input wire logic thermal_shutdown_i,
  input wire logic supply_low_lockout_i,
  // gate drive
  output logic gate_hs_a_o,
  output logic gate_ls_a_o,
  output logic gate_hs_b_o,
  output logic gate_ls_b_o,
  output logic sleep_o
);
  localparam int FT_W = $clog2(ILIM_FAULT_CYC + 1);
  localparam logic [FT_W-1:0] FT_LAST = FT_W'(ILIM_FAULT_CYC - 1);
  localparam int NB = 9;

  typedef enum logic [1:0] {ST_SLEEP, ST_ACTIVE, ST_OCP_LOCK} state_t;

  // synchroniser stages for single-bit pins
  logic [NB-1:0] pin_meta_q;
  logic [NB-1:0] pin_sync_q;
  // synchroniser stages for analog codes
  logic [3*ADC_W+1:0] code_meta_q;
  logic [3*ADC_W+1:0] code_sync_q;
  logic [1:0] mode; // synchronised direction code
  logic sense_s; // sense above 200 mV
  logic [3:0] ocp_s; // per fet current limit active
  logic tsd_s; // overtemperature
  logic supply_low_lockout_s; // supply low
  logic core_rst; // reset of all block logic after the synchronisers
  logic [1:0] prev_mode_q; // direction of the last cycle
  state_t state_q;
  logic [8:0] ilim_cnt_q; // current limit deglitch
  logic ilim_act; // current limit in force
  logic [FT_W-1:0] fault_cnt_q; // current limit fault timer
  logic ilim_fault_q; // latched limit fault
  logic [3:0] ocp_hit; // per fet deglitched trip
  logic fault_active; // any fault present
  logic error_flag_n_q;
  logic [3:0] gate_d; // hs_a, ls_a, hs_b, ls_b
  logic [3:0] gate_q;
  logic sleep_q;
  logic [hbridge_pkg::NUM_EV-1:0] status_q; // sticky events
  logic [hbridge_pkg::NUM_EV-1:0] mask_q; // interrupt enables
  logic [hbridge_pkg::NUM_EV-1:0] ev; // event levels
  logic irq_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic wb_req; // request present
  logic wb_wr; // write takes effect this edge
  logic [31:0] rdata_d;

  regulation_if #(.ADC_W(ADC_W)) reg_bus ();

  // two-stage synchronisers, reset only by the port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 9'h000;
      pin_sync_q <= 9'h000;
    end else begin
      pin_meta_q <= {dir_ctrl_a_i, dir_ctrl_b_i, current_sense_in_i,
        fet_overcurrent_i, thermal_shutdown_i, supply_low_lockout_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // codes change slowly against the clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_meta_q <= '0;
      code_sync_q <= '0;
    end else begin
      code_meta_q <= {speed_setpoint_in_i, bridge_avg_i, supply_level_i};
      code_sync_q <= code_meta_q;
    end
  end

  assign mode = pin_sync_q[8:7];
  assign sense_s = pin_sync_q[6];
  assign ocp_s = pin_sync_q[5:2];
  assign tsd_s = pin_sync_q[1];
  assign supply_low_lockout_s = pin_sync_q[0];
  // supply loss holds everything past the synchronisers in reset
  assign core_rst = rst_i || supply_low_lockout_s;

  // regulator connection
  assign reg_bus.run = (state_q == ST_ACTIVE) &&
    (mode == hbridge_pkg::MODE_FWD || mode == hbridge_pkg::MODE_REV);
  // leaving brake or standby for a drive restarts the ramp
  assign reg_bus.restart = reg_bus.run &&
    (prev_mode_q == hbridge_pkg::MODE_COAST ||
     prev_mode_q == hbridge_pkg::MODE_BRAKE);
  assign reg_bus.ilim = ilim_act;
  assign reg_bus.setpoint = code_sync_q[3*ADC_W+1:2*ADC_W+2];
  assign reg_bus.bridge_avg = code_sync_q[2*ADC_W+1:ADC_W+2];
  assign reg_bus.supply = code_sync_q[ADC_W+1:0];

  pwm_regulator #(.ADC_W(ADC_W)) u_regulator (
    .clk_i(clk_i),
    .rst_i(core_rst),
    .reg_if(reg_bus.regl)
  );

  // previous direction for ramp restart
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      prev_mode_q <= hbridge_pkg::MODE_COAST;
    end else begin
      prev_mode_q <= mode;
    end
  end

  // control state
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      state_q <= ST_SLEEP;
    end else begin
      case (state_q)
        ST_OCP_LOCK: begin
          state_q <= ST_OCP_LOCK;
        end
        ST_SLEEP, ST_ACTIVE: begin
          if (|ocp_hit) begin
            state_q <= ST_OCP_LOCK;
          end else if (mode == hbridge_pkg::MODE_COAST) begin
            state_q <= ST_SLEEP;
          end else begin
            state_q <= ST_ACTIVE;
          end
        end
        default: begin
          state_q <= ST_SLEEP;
        end
      endcase
    end
  end

  // sense deglitch, saturates when the limit is in force
  always_ff @(posedge clk_i) begin
    if (core_rst || !sense_s) begin
      ilim_cnt_q <= 9'h000;
    end else if (ilim_cnt_q != hbridge_pkg::ILIM_CYC_V) begin
      ilim_cnt_q <= ilim_cnt_q + 9'h001;
    end
  end
  assign ilim_act = (ilim_cnt_q == hbridge_pkg::ILIM_CYC_V);

  // long timer on a persisting current limit
  always_ff @(posedge clk_i) begin
    if (core_rst || !ilim_act || mode == hbridge_pkg::MODE_COAST) begin
      fault_cnt_q <= '0;
    end else if (fault_cnt_q != FT_LAST) begin
      fault_cnt_q <= fault_cnt_q + FT_W'(1);
    end
  end

  // limit fault: set after the timer, cleared by standby
  always_ff @(posedge clk_i) begin
    if (core_rst || mode == hbridge_pkg::MODE_COAST) begin
      ilim_fault_q <= 1'b0;
    end else if (ilim_act && fault_cnt_q == FT_LAST) begin
      ilim_fault_q <= 1'b1;
    end
  end

  // one deglitch counter per fet
  for (genvar i = 0; i < 4; i++) begin : g_ocp
    logic [7:0] cnt_q;
    always_ff @(posedge clk_i) begin
      if (core_rst || !ocp_s[i]) begin
        cnt_q <= 8'h00;
      end else if (cnt_q != hbridge_pkg::OCP_CYC_V) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
    assign ocp_hit[i] = (cnt_q == hbridge_pkg::OCP_CYC_V);
  end

  // fault pin, low in reset and while any fault holds
  assign fault_active = tsd_s || ilim_fault_q || (state_q == ST_OCP_LOCK);
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      error_flag_n_q <= 1'b0;
    end else begin
      error_flag_n_q <= !fault_active;
    end
  end

  // gate decode from direction and pwm phase
  always_comb begin
    gate_d = 4'h0;
    if (state_q == ST_ACTIVE && !tsd_s) begin
      case (mode)
        hbridge_pkg::MODE_FWD: begin
          // a high, b low while on; both high sides while off
          gate_d = reg_bus.pwm_on ? 4'h9 : 4'hA;
        end
        hbridge_pkg::MODE_REV: begin
          gate_d = reg_bus.pwm_on ? 4'h6 : 4'hA;
        end
        hbridge_pkg::MODE_BRAKE: begin
          gate_d = 4'hA;
        end
        default: begin
          gate_d = 4'h0;
        end
      endcase
    end
  end

  // registered gate drive and sleep
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      gate_q <= 4'h0;
      sleep_q <= 1'b1;
    end else begin
      gate_q <= gate_d;
      sleep_q <= (state_q == ST_SLEEP) || (mode == hbridge_pkg::MODE_COAST);
    end
  end

  assign gate_hs_a_o = gate_q[3];
  assign gate_ls_a_o = gate_q[2];
  assign gate_hs_b_o = gate_q[1];
  assign gate_ls_b_o = gate_q[0];
  assign sleep_o = sleep_q;
  assign error_flag_n_o = error_flag_n_q;

  // wishbone handshake, ack one cycle after the request
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_we_i && ack_q && wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req && !ack_q;
    end
  end

  // event levels
  assign ev[hbridge_pkg::EV_ILIM_BIT] = ilim_fault_q;
  assign ev[hbridge_pkg::EV_OCP_BIT] = (state_q == ST_OCP_LOCK);
  assign ev[hbridge_pkg::EV_OT_BIT] = tsd_s;

  // sticky status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      status_q <= hbridge_pkg::STATUS_RST;
    end else if (wb_wr && wb_adr_i == hbridge_pkg::STATUS_OFS) begin
      status_q <= (status_q & ~wb_dat_i[hbridge_pkg::NUM_EV-1:0]) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      mask_q <= hbridge_pkg::MASK_RST;
    end else if (wb_wr && wb_adr_i == hbridge_pkg::MASK_OFS) begin
      mask_q <= wb_dat_i[hbridge_pkg::NUM_EV-1:0];
    end
  end

  // level interrupt
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end
  assign irq_o = irq_q;

  // read mux, unmapped reads as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (wb_adr_i)
      hbridge_pkg::STATUS_OFS: begin
        rdata_d[hbridge_pkg::NUM_EV-1:0] = status_q;
      end
      hbridge_pkg::MASK_OFS: begin
        rdata_d[hbridge_pkg::NUM_EV-1:0] = mask_q;
      end
      hbridge_pkg::LIVE_OFS: begin
        rdata_d[hbridge_pkg::LIVE_FAULT_BIT] = fault_active;
        rdata_d[hbridge_pkg::LIVE_OT_BIT] = tsd_s;
        rdata_d[hbridge_pkg::LIVE_ILIM_BIT] = ilim_act;
        rdata_d[hbridge_pkg::LIVE_OCP_BIT] = (state_q == ST_OCP_LOCK);
        rdata_d[hbridge_pkg::LIVE_SLEEP_BIT] = sleep_q;
        rdata_d[hbridge_pkg::LIVE_DUTY_LSB +: hbridge_pkg::DUTY_W] = reg_bus.duty;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // read data captured as ack rises
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (wb_req && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end
  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (core_rst);
  sequence s_standby2;
    (mode == hbridge_pkg::MODE_COAST)[*2];
  endsequence
  a_coast_all_off: assert property (s_standby2 |=> gate_q == 4'h0 && sleep_o)
    else $error("standby did not turn drivers off");
  a_coast_clears_fault: assert property ((mode == hbridge_pkg::MODE_COAST)
    |=> !ilim_fault_q) else $error("limit fault not cleared");
  a_ocp_lock_hold: assert property (|ocp_hit |=> state_q == ST_OCP_LOCK
    ##1 (gate_q == 4'h0 && !error_flag_n_o)) else $error("overcurrent not latched");
  a_ocp_no_exit: assert property (state_q == ST_OCP_LOCK |=> state_q == ST_OCP_LOCK)
    else $error("overcurrent lock released");
  a_tsd_gates_off: assert property (tsd_s |=> gate_q == 4'h0
    && status_q[hbridge_pkg::EV_OT_BIT]) else $error("overtemp did not disable");
  a_fault_pin_low: assert property (fault_active |=> !error_flag_n_o)
    else $error("fault pin not driven low");
  a_fault_pin_free: assert property (!fault_active |=> error_flag_n_o)
    else $error("fault pin not released");
  a_off_time_hs: assert property (state_q == ST_ACTIVE && !tsd_s
    && mode == hbridge_pkg::MODE_FWD && !reg_bus.pwm_on |=> gate_q == 4'hA)
    else $error("off time not recirculating");
  a_ilim_fault_set: assert property (ilim_act && fault_cnt_q == FT_LAST
    && mode != hbridge_pkg::MODE_COAST |=> ilim_fault_q && state_q != ST_SLEEP)
    else $error("limit fault not registered");
  a_ack_one_cycle: assert property (ack_q |=> !ack_q)
    else $error("ack held too long");
endmodule

// ==== hw/hbridge_pkg.sv ====
// constants shared by the motor control block and its pwm regulator
// assumes a 100 MHz core clock
package hbridge_pkg;
  // clock and pwm timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PWM_FREQ_HZ = 44_500;
  localparam int PWM_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int RAMP_MAX_US = 12_000;
  localparam int RAMP_PERIODS = RAMP_MAX_US * (PWM_FREQ_HZ / 100) / 10_000;
  localparam int DUTY_STEP = (PWM_CYC + RAMP_PERIODS - 1) / RAMP_PERIODS;
  localparam int DUTY_W = 12;
  localparam logic [DUTY_W-1:0] PWM_TOP = DUTY_W'(PWM_CYC);
  localparam logic [DUTY_W-1:0] DUTY_STEP_V = DUTY_W'(DUTY_STEP);
  // deglitch and fault times
  localparam int OCP_DEGLITCH_NS = 2000;
  localparam int OCP_CYC = (OCP_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] OCP_CYC_V = 8'(OCP_CYC);
  localparam int ILIM_DEGLITCH_NS = 3000;
  localparam int ILIM_CYC = (ILIM_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] ILIM_CYC_V = 9'(ILIM_CYC);
  localparam int ILIM_FAULT_MS = 275;
  localparam int ILIM_FAULT_CYC = ILIM_FAULT_MS * (1_000_000 / CLK_PERIOD_NS);
  // analog code width
  localparam int ADC_W_DEF = 10;
  // register offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] LIVE_OFS = 8'h08;
  // event bits of status and mask
  localparam int NUM_EV = 3;
  localparam int EV_ILIM_BIT = 0;
  localparam int EV_OCP_BIT = 1;
  localparam int EV_OT_BIT = 2;
  localparam logic [NUM_EV-1:0] STATUS_RST = 3'h0;
  localparam logic [NUM_EV-1:0] MASK_RST = 3'h0;
  // live register fields
  localparam int LIVE_FAULT_BIT = 0;
  localparam int LIVE_OT_BIT = 1;
  localparam int LIVE_ILIM_BIT = 2;
  localparam int LIVE_OCP_BIT = 3;
  localparam int LIVE_SLEEP_BIT = 4;
  localparam int LIVE_DUTY_LSB = 16;
  // direction input codes
  localparam logic [1:0] MODE_COAST = 2'h0;
  localparam logic [1:0] MODE_REV = 2'h1;
  localparam logic [1:0] MODE_FWD = 2'h2;
  localparam logic [1:0] MODE_BRAKE = 2'h3;
endpackage

// ==== hw/pwm_regulator.sv ====
// voltage regulating pwm with soft start and current limit back-off
// assumes synchronised analog codes and a reset that covers supply loss
`timescale 1ns/10ps
module pwm_regulator #(
  parameter int ADC_W = hbridge_pkg::ADC_W_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to the bridge control
  regulation_if.regl reg_if
);
  logic [hbridge_pkg::DUTY_W-1:0] cnt_q; // position in the pwm period
  logic [hbridge_pkg::DUTY_W-1:0] duty_q; // on time in cycles
  logic period_end; // last cycle of a period
  logic above; // scaled average above setpoint
  logic below; // scaled average below setpoint
  logic full_req; // target exceeds supply

  assign period_end = (cnt_q == hbridge_pkg::PWM_TOP - 12'h001);
  // average divided by 4 against the setpoint
  assign above = {2'h0, reg_if.bridge_avg[ADC_W-1:2]} > reg_if.setpoint;
  assign below = {2'h0, reg_if.bridge_avg[ADC_W-1:2]} < reg_if.setpoint;
  // four times the setpoint is the programmed voltage
  assign full_req = {reg_if.setpoint, 2'h0} > reg_if.supply;
  assign reg_if.full = full_req;
  assign reg_if.duty = duty_q;
  assign reg_if.pwm_on = reg_if.run && (cnt_q < duty_q);

  // period counter, restarted with the ramp
  always_ff @(posedge clk_i) begin
    if (rst_i || !reg_if.run || reg_if.restart || period_end) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // duty moves at most one step per period, or straight to full when the target exceeds supply and the current limit is not in force
  always_ff @(posedge clk_i) begin
    if (rst_i || !reg_if.run || reg_if.restart) begin
      duty_q <= 12'h000;
    end else if (period_end) begin
      if (reg_if.ilim) begin
        // back off while current is at the limit
        duty_q <= (duty_q < hbridge_pkg::DUTY_STEP_V) ? 12'h000 :
          duty_q - hbridge_pkg::DUTY_STEP_V;
      end else if (full_req) begin
        duty_q <= hbridge_pkg::PWM_TOP;
      end else if (below) begin
        // gradual rise gives the soft start
        duty_q <= (duty_q > hbridge_pkg::PWM_TOP - hbridge_pkg::DUTY_STEP_V) ?
          hbridge_pkg::PWM_TOP : duty_q + hbridge_pkg::DUTY_STEP_V;
      end else if (above) begin
        duty_q <= (duty_q < hbridge_pkg::DUTY_STEP_V) ? 12'h000 :
          duty_q - hbridge_pkg::DUTY_STEP_V;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_step;
    period_end && reg_if.run && !reg_if.restart;
  endsequence
  a_restart_zero_duty: assert property (reg_if.restart |=> duty_q == 12'h000
    && cnt_q == 12'h000) else $error("duty not zero after restart");
  a_full_duty_set: assert property (s_step ##0 (full_req && !reg_if.ilim)
    |=> duty_q == hbridge_pkg::PWM_TOP) else $error("full duty not reached");
  a_ilim_duty_down: assert property (s_step ##0 (reg_if.ilim
    && duty_q >= hbridge_pkg::DUTY_STEP_V)
    |=> duty_q == $past(duty_q) - hbridge_pkg::DUTY_STEP_V)
    else $error("duty not reduced at current limit");
endmodule

// ==== hw/regulation_if.sv ====
// signals between the bridge control and the pwm regulator
// assumes both ends share one clock
`timescale 1ns/10ps
interface regulation_if #(
  parameter int ADC_W = hbridge_pkg::ADC_W_DEF
);
  logic run; // forward or reverse drive
  logic restart; // pulse: ramp again from zero duty
  logic ilim; // deglitched current limit
  logic [ADC_W-1:0] bridge_avg; // averaged bridge voltage code
  logic [ADC_W-1:0] setpoint; // speed setpoint code
  logic [ADC_W+1:0] supply; // supply voltage code
  logic full; // regulation bypassed, full duty
  logic pwm_on; // on phase of the pwm period
  logic [hbridge_pkg::DUTY_W-1:0] duty; // duty in clock cycles
  modport ctrl (output run, restart, ilim, bridge_avg, setpoint, supply,
    input full, pwm_on, duty);
  modport regl (input run, restart, ilim, bridge_avg, setpoint, supply,
    output full, pwm_on, duty);
endinterface

// ==== tb/host_ctrl_model.sv ====
// host controller model: drives the direction pins, watches the fault pin
// assumes the bench calls set_mode right after a rising clock edge
`timescale 1ns/10ps
module host_ctrl_model (
  // clock
  input wire logic clk_i,
  // fault pin from the driver
  input wire logic error_flag_n_i,
  // direction pins
  output logic dir_ctrl_a_o,
  output logic dir_ctrl_b_o
);
  // pins start in coast
  initial begin
    dir_ctrl_a_o = 1'b0;
    dir_ctrl_b_o = 1'b0;
  end
  // one new code per call, then held; speed is never set by toggling
  task automatic set_mode(input logic [1:0] code);
    {dir_ctrl_a_o, dir_ctrl_b_o} <= code;
    repeat (8) @(posedge clk_i);
  endtask
  // host view of the fault pin
  function automatic logic fault_seen();
    return error_flag_n_i === 1'b0;
  endfunction
endmodule

// ==== tb/tb_hbridge_motor_control.sv ====
// bench for the h-bridge motor control: bus, pins and protection paths
// assumes a 100 MHz clock and a short limit fault time in simulation
`timescale 1ns/10ps
module tb_hbridge_motor_control;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, rd_v, d1;
  logic wb_ack_o, irq_o, dir_a, dir_b, error_flag_n_o, sleep_o;
  logic [9:0] setpoint = 10'h080, bridge_avg = 10'h000;
  logic [11:0] supply = 12'hFFF;
  logic sense = 1'b0, thermal = 1'b0, supply_low_lockout = 1'b0;
  logic [3:0] fet_oc = 4'h0;
  logic g_hs_a, g_ls_a, g_hs_b, g_ls_b;
  wire [3:0] gates = {g_hs_a, g_ls_a, g_hs_b, g_ls_b};
  int bad_count = 0, comparisons = 0;
  localparam int PER = hbridge_pkg::PWM_CYC;
  // clock, 10 ns period
  always #5 clk_i = ~clk_i;
  hbridge_motor_control #(.ILIM_FAULT_CYC(2000)) u_hbridge_motor_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .dir_ctrl_a_i(dir_a), .dir_ctrl_b_i(dir_b), .error_flag_n_o(error_flag_n_o),
    .speed_setpoint_in_i(setpoint), .bridge_avg_i(bridge_avg),
    .supply_level_i(supply), .current_sense_in_i(sense), .fet_overcurrent_i(fet_oc),
    .thermal_shutdown_i(thermal), .supply_low_lockout_i(supply_low_lockout),
    .gate_hs_a_o(g_hs_a), .gate_ls_a_o(g_ls_a), .gate_hs_b_o(g_hs_b),
    .gate_ls_b_o(g_ls_b), .sleep_o(sleep_o));
  host_ctrl_model u_host_ctrl_model (
    .clk_i(clk_i), .error_flag_n_i(error_flag_n_o),
    .dir_ctrl_a_o(dir_a), .dir_ctrl_b_o(dir_b));
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd_v = wb_dat_o;
    chk("wb ack", 32'h1, 32'(n < 50));
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // wait for a gate pattern under a bound, then compare it
  task automatic wait_gates(input logic [3:0] v, input int lim);
    int n;
    n = 0;
    while (gates !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("gates", 32'(v), 32'(gates));
  endtask
  // reset for six cycles
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // duty field of the live register
  task automatic rd_duty(output logic [31:0] d);
    wb_xfer(1'b0, hbridge_pkg::LIVE_OFS, 32'h0);
    d = {20'h0, rd_v[27:16]};
  endtask
  // hang guard
  initial begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
  // main sequence
  initial begin
    do_reset();
    chk("fault pin", 32'h1, 32'(error_flag_n_o));
    chk("sleep", 32'h1, 32'(sleep_o));
    wb_xfer(1'b0, hbridge_pkg::STATUS_OFS, 32'h0);
    chk("status", 32'h0, rd_v);
    wb_xfer(1'b0, hbridge_pkg::MASK_OFS, 32'h0);
    chk("mask", 32'h0, rd_v);
    wb_xfer(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rd_v);
    u_host_ctrl_model.set_mode(hbridge_pkg::MODE_BRAKE);
    wait_gates(4'hA, 20);
    chk("sleep", 32'h0, 32'(sleep_o));
    // brake to forward restarts at zero duty, off time on both high sides
    u_host_ctrl_model.set_mode(hbridge_pkg::MODE_FWD);
    chk("gates", 32'hA, 32'(gates));
    rd_duty(d1);
    chk("duty", 32'h0, d1);
    wait_gates(4'h9, 6 * PER);
    rd_duty(d1);
    repeat (3 * PER) @(posedge clk_i);
    rd_duty(rd_v);
    chk("duty rises", 32'h1, 32'(rd_v > d1));
    bridge_avg <= 10'h3FF;
    rd_duty(d1);
    repeat (3 * PER) @(posedge clk_i);
    rd_duty(rd_v);
    chk("duty falls", 32'h1, 32'(rd_v < d1));
    bridge_avg <= 10'h000;
    // target above supply: full duty, bridge on for the whole period
    supply <= 12'h100;
    repeat (2 * PER) @(posedge clk_i);
    rd_duty(d1);
    chk("full duty", 32'(hbridge_pkg::PWM_CYC), d1);
    chk("gates", 32'h9, 32'(gates));
    supply <= 12'hFFF;
    u_host_ctrl_model.set_mode(hbridge_pkg::MODE_REV);
    wait_gates(4'h6, 3 * PER);
    // current limit: duty backs off, then the fault flags while driving
    sense <= 1'b1;
    repeat (400) @(posedge clk_i);
    rd_duty(d1);
    repeat (2 * PER) @(posedge clk_i);
    rd_duty(rd_v);
    chk("limit duty", 32'h1, 32'(rd_v < d1));
    chk("fault pin", 32'h0, 32'(error_flag_n_o));
    chk("sleep", 32'h0, 32'(sleep_o));
    sense <= 1'b0;
    wb_xfer(1'b0, hbridge_pkg::STATUS_OFS, 32'h0);
    chk("status limit", 32'h1, rd_v & 32'h1);
    u_host_ctrl_model.set_mode(hbridge_pkg::MODE_COAST);
    chk("fault pin", 32'h1, 32'(error_flag_n_o));
    chk("gates", 32'h0, 32'(gates));
    chk("sleep", 32'h1, 32'(sleep_o));
    wb_xfer(1'b1, hbridge_pkg::STATUS_OFS, 32'h7);
    wb_xfer(1'b1, hbridge_pkg::MASK_OFS, 32'h4);
    // overtemperature: off, fault, status, interrupt, auto resume
    u_host_ctrl_model.set_mode(hbridge_pkg::MODE_BRAKE);
    thermal <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("gates", 32'h0, 32'(gates));
    chk("fault pin", 32'h0, 32'(error_flag_n_o));
    chk("irq", 32'h1, 32'(irq_o));
    wb_xfer(1'b0, hbridge_pkg::STATUS_OFS, 32'h0);
    chk("status ot", 32'h4, rd_v);
    thermal <= 1'b0;
    wait_gates(4'hA, 20);
    chk("fault pin", 32'h1, 32'(error_flag_n_o));
    wb_xfer(1'b1, hbridge_pkg::STATUS_OFS, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h0, 32'(irq_o));
    // undervoltage holds the logic in reset, then resumes
    supply_low_lockout <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("fault pin", 32'h0, 32'(error_flag_n_o));
    chk("gates", 32'h0, 32'(gates));
    supply_low_lockout <= 1'b0;
    wait_gates(4'hA, 20);
    chk("fault pin", 32'h1, 32'(error_flag_n_o));
    // each transistor's overcurrent: short glitch passes, long one locks
    for (int i = 0; i < 4; i++) begin
      do_reset();
      u_host_ctrl_model.set_mode(hbridge_pkg::MODE_BRAKE);
      fet_oc <= 4'h1 << i;
      repeat (150) @(posedge clk_i);
      fet_oc <= 4'h0;
      repeat (4) @(posedge clk_i);
      chk("fault pin", 32'h1, 32'(error_flag_n_o));
      fet_oc <= 4'h1 << i;
      repeat (260) @(posedge clk_i);
      fet_oc <= 4'h0;
      chk("gates", 32'h0, 32'(gates));
      chk("fault pin", 32'h0, 32'(error_flag_n_o));
      u_host_ctrl_model.set_mode(hbridge_pkg::MODE_COAST);
      chk("lock sleep", 32'h1, 32'(sleep_o));
      u_host_ctrl_model.set_mode(hbridge_pkg::MODE_BRAKE);
      chk("locked gates", 32'h0, 32'(gates));
      chk("host fault", 32'h1, 32'(u_host_ctrl_model.fault_seen()));
    end
    complete_run();
  end
endmodule
